//--- design/abc_bank.sv
// apb register bank holding the analog bias and power configuration
//
// Function
// [RQ1] control word bit 1 powers the column multiplexer up when set, bit 2 enables column bias.
// [RQ2] the level register resets to 0xb5a with double slope, triple slope, antibloom, cascode.
// [RQ3] level bit 13 turns on column test patterns and bit 14 picks the level, both reset low.
// [RQ4] bit 0 at index 48 powers all 64 column front-ends up when set and resets low.
// [RQ5] the reference setup resets to 0x888b and bit 0 set selects the external resistor.
// [RQ6] reference setup holds precharge, column bias and pump trims of 4 bits, each reset to 8.
// [RQ7] front-end trims reset to 0x53c8 with current, converter and 7-bit gain-stage trims.
// [RQ8] selector trims reset to 0x8888 with first stage, second stage and delay trims.
// [RQ9] control word bit 0 powers the image core up when set and resets low.
// [RQ10] every register loads its default on reset, holds writes and reads back unchanged, except level bit 15, which reads as zero.
`timescale 1ns/1ps
`default_nettype none

module abc_bank
  import abc_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       pclk_en,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [abc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [abc_pkg::DATA_W-1:0] pwdata,
  output logic      [abc_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            core_powerup,
  output logic                            mux_powerup,
  output logic                            colbias_enable,
  output logic      [3:0]                 double_slope_level,
  output logic      [3:0]                 triple_slope_level,
  output logic      [2:0]                 antibloom_level,
  output logic      [1:0]                 cascode_level,
  output logic                            testpattern_enable,
  output logic                            inject_level,
  output logic                            frontend_powerup,
  output logic                            bandgap_powerup,
  output logic                            external_resistor,
  output logic      [3:0]                 precharge_trim,
  output logic      [3:0]                 colbias_trim,
  output logic      [3:0]                 pump_current_trim,
  output logic      [3:0]                 frontend_current_trim,
  output logic      [3:0]                 converter_trim,
  output logic      [6:0]                 gain_stage_trim,
  output logic      [3:0]                 selector_first_stage_trim,
  output logic      [3:0]                 selector_second_stage_trim,
  output logic      [3:0]                 selector_delay_trim
);

  import abc_pkg::*;

  // ----------------------------------------------------------------
  // reset table per storage slot
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_TABLE [NUM_REGS] = '{
    RST_COLUMN_READOUT_ENABLES,
    RST_PIXEL_ARRAY_LEVELS,
    RST_FRONTEND_POWERUP,
    RST_REFERENCE_POWERUP,
    RST_CURRENT_REFERENCE_SETUP,
    RST_FRONTEND_CURRENT_TRIMS,
    RST_COLUMN_SELECTOR_TRIMS
  };

  logic [REG_W-1:0]  store_reg [NUM_REGS];
  logic [IDX_W-1:0]  slot;
  logic              hit;
  logic              setup_phase;
  logic              wr_commit;
  logic [REG_W-1:0]  rd_value;

  // ----------------------------------------------------------------
  // address decode: word index into storage slot
  // ----------------------------------------------------------------
  always_comb begin
    slot = SLOT_READOUT;
    hit  = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      case (paddr[ADDR_W-1:2])
        10'(IDX_COLUMN_READOUT_ENABLES): begin
          slot = SLOT_READOUT;
          hit  = 1'b1;
        end
        10'(IDX_PIXEL_ARRAY_LEVELS): begin
          slot = SLOT_LEVELS;
          hit  = 1'b1;
        end
        10'(IDX_FRONTEND_POWERUP): begin
          slot = SLOT_FE_PWR;
          hit  = 1'b1;
        end
        10'(IDX_REFERENCE_POWERUP): begin
          slot = SLOT_REF_PWR;
          hit  = 1'b1;
        end
        10'(IDX_CURRENT_REFERENCE_SETUP): begin
          slot = SLOT_REF_CFG;
          hit  = 1'b1;
        end
        10'(IDX_FRONTEND_CURRENT_TRIMS): begin
          slot = SLOT_FE_TRIM;
          hit  = 1'b1;
        end
        10'(IDX_COLUMN_SELECTOR_TRIMS): begin
          slot = SLOT_SEL_TRIM;
          hit  = 1'b1;
        end
        default: begin
          slot = SLOT_READOUT;
          hit  = 1'b0;
        end
      endcase
    end
  end

  // setup phase starts a zero-wait answer; commit happens in access phase
  assign setup_phase = psel & ~penable;
  assign wr_commit   = psel & penable & pready & pwrite & hit;

  // ----------------------------------------------------------------
  // handshake: pready rises in the access phase, low otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (pclk_en) begin
      pready <= setup_phase;
    end
  end

  // unmapped or misaligned addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (pclk_en) begin
      pslverr <= setup_phase & ~hit;
    end
  end

  // read value: reserved level bit 15 reads as zero
  always_comb begin
    rd_value = store_reg[slot];
    if (slot == SLOT_LEVELS) begin
      rd_value[POS_LEVELS_RSVD] = 1'b0;
    end
  end

  // read data captured in setup, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (pclk_en) begin
      if (setup_phase && !pwrite && hit) begin
        prdata <= {{(DATA_W-REG_W){1'b0}}, rd_value}; // [RQ10]
      end else if (setup_phase) begin
        prdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // storage: each slot loads its default and holds until written
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_store
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        store_reg[i] <= RST_TABLE[i]; // [RQ10] [RQ2] [RQ5] [RQ7] [RQ8]
      end else if (pclk_en && wr_commit && (slot == IDX_W'(i))) begin
        store_reg[i] <= pwdata[REG_W-1:0]; // [RQ10]
      end
    end
  end

  // ----------------------------------------------------------------
  // field outputs, taken straight from the storage flops
  // ----------------------------------------------------------------
  // image core control word
  assign core_powerup   = store_reg[SLOT_READOUT][POS_CORE_POWERUP];   // [RQ9]
  assign mux_powerup    = store_reg[SLOT_READOUT][POS_MUX_POWERUP];    // [RQ1]
  assign colbias_enable = store_reg[SLOT_READOUT][POS_COLBIAS_ENABLE]; // [RQ1]

  // pixel array levels and column test pattern
  assign double_slope_level = store_reg[SLOT_LEVELS][POS_DOUBLE_SLOPE +: 4]; // [RQ2]
  assign triple_slope_level = store_reg[SLOT_LEVELS][POS_TRIPLE_SLOPE +: 4]; // [RQ2]
  assign antibloom_level    = store_reg[SLOT_LEVELS][POS_ANTIBLOOM +: 3];    // [RQ2]
  assign cascode_level      = store_reg[SLOT_LEVELS][POS_CASCODE +: 2];      // [RQ2]
  assign testpattern_enable = store_reg[SLOT_LEVELS][POS_TESTPATTERN];       // [RQ3]
  assign inject_level       = store_reg[SLOT_LEVELS][POS_INJECTLEVEL];       // [RQ3]

  // power enables for front-ends and bandgap
  assign frontend_powerup = store_reg[SLOT_FE_PWR][POS_FE_POWERUP];       // [RQ4]
  assign bandgap_powerup  = store_reg[SLOT_REF_PWR][POS_BANDGAP_POWERUP];

  // current reference setup
  assign external_resistor = store_reg[SLOT_REF_CFG][POS_EXT_RESISTOR];       // [RQ5]
  assign precharge_trim    = store_reg[SLOT_REF_CFG][POS_PRECHARGE_TRIM +: 4]; // [RQ6]
  assign colbias_trim      = store_reg[SLOT_REF_CFG][POS_COLBIAS_TRIM +: 4];   // [RQ6]
  assign pump_current_trim = store_reg[SLOT_REF_CFG][POS_PUMP_TRIM +: 4];      // [RQ6]

  // front-end current trims
  assign frontend_current_trim = store_reg[SLOT_FE_TRIM][POS_FE_CURRENT_TRIM +: 4]; // [RQ7]
  assign converter_trim        = store_reg[SLOT_FE_TRIM][POS_CONVERTER_TRIM +: 4];  // [RQ7]
  assign gain_stage_trim       = store_reg[SLOT_FE_TRIM][POS_GAIN_STAGE_TRIM +: 7]; // [RQ7]

  // column selector trims
  assign selector_first_stage_trim  = store_reg[SLOT_SEL_TRIM][POS_SEL_FIRST_TRIM +: 4];  // [RQ8]
  assign selector_second_stage_trim = store_reg[SLOT_SEL_TRIM][POS_SEL_SECOND_TRIM +: 4]; // [RQ8]
  assign selector_delay_trim        = store_reg[SLOT_SEL_TRIM][POS_SEL_DELAY_TRIM +: 4];  // [RQ8]

endmodule

`default_nettype wire

//--- design/abc_pkg.sv
// constants for the analog bias configuration register bank
package abc_pkg;

  // ----------------------------------------------------------------
  // register geometry
  // ----------------------------------------------------------------
  localparam int unsigned REG_W    = 16;
  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned IDX_W    = 3;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_COLUMN_READOUT_ENABLES  = 8'h28;
  localparam logic [7:0] IDX_PIXEL_ARRAY_LEVELS      = 8'h29;
  localparam logic [7:0] IDX_FRONTEND_POWERUP        = 8'h30;
  localparam logic [7:0] IDX_REFERENCE_POWERUP       = 8'h40;
  localparam logic [7:0] IDX_CURRENT_REFERENCE_SETUP = 8'h41;
  localparam logic [7:0] IDX_FRONTEND_CURRENT_TRIMS  = 8'h42;
  localparam logic [7:0] IDX_COLUMN_SELECTOR_TRIMS   = 8'h43;

  // ----------------------------------------------------------------
  // slots in the storage array
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] SLOT_READOUT  = 3'h0;
  localparam logic [IDX_W-1:0] SLOT_LEVELS   = 3'h1;
  localparam logic [IDX_W-1:0] SLOT_FE_PWR   = 3'h2;
  localparam logic [IDX_W-1:0] SLOT_REF_PWR  = 3'h3;
  localparam logic [IDX_W-1:0] SLOT_REF_CFG  = 3'h4;
  localparam logic [IDX_W-1:0] SLOT_FE_TRIM  = 3'h5;
  localparam logic [IDX_W-1:0] SLOT_SEL_TRIM = 3'h6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_COLUMN_READOUT_ENABLES  = 16'h0000;
  localparam logic [REG_W-1:0] RST_PIXEL_ARRAY_LEVELS      = 16'h0b5a;
  localparam logic [REG_W-1:0] RST_FRONTEND_POWERUP        = 16'h0000;
  localparam logic [REG_W-1:0] RST_REFERENCE_POWERUP       = 16'h0000;
  localparam logic [REG_W-1:0] RST_CURRENT_REFERENCE_SETUP = 16'h888b;
  localparam logic [REG_W-1:0] RST_FRONTEND_CURRENT_TRIMS  = 16'h53c8;
  localparam logic [REG_W-1:0] RST_COLUMN_SELECTOR_TRIMS   = 16'h8888;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_CORE_POWERUP      = 0;
  localparam int unsigned POS_MUX_POWERUP       = 1;
  localparam int unsigned POS_COLBIAS_ENABLE    = 2;
  localparam int unsigned POS_DOUBLE_SLOPE      = 0;
  localparam int unsigned POS_TRIPLE_SLOPE      = 4;
  localparam int unsigned POS_ANTIBLOOM         = 8;
  localparam int unsigned POS_CASCODE           = 11;
  localparam int unsigned POS_TESTPATTERN       = 13;
  localparam int unsigned POS_INJECTLEVEL       = 14;
  localparam int unsigned POS_LEVELS_RSVD       = 15;
  localparam int unsigned POS_FE_POWERUP        = 0;
  localparam int unsigned POS_BANDGAP_POWERUP   = 0;
  localparam int unsigned POS_EXT_RESISTOR      = 0;
  localparam int unsigned POS_PRECHARGE_TRIM    = 4;
  localparam int unsigned POS_COLBIAS_TRIM      = 8;
  localparam int unsigned POS_PUMP_TRIM         = 12;
  localparam int unsigned POS_FE_CURRENT_TRIM   = 0;
  localparam int unsigned POS_CONVERTER_TRIM    = 4;
  localparam int unsigned POS_GAIN_STAGE_TRIM   = 8;
  localparam int unsigned POS_SEL_FIRST_TRIM    = 0;
  localparam int unsigned POS_SEL_SECOND_TRIM   = 4;
  localparam int unsigned POS_SEL_DELAY_TRIM    = 8;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

endpackage

//--- tb/abc_bank_chk.sv
// assertion checker for the bias configuration bank
`timescale 1ns/1ps
`default_nettype none
module abc_bank_chk
  import abc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_powerup,
  input wire logic        mux_powerup,
  input wire logic        colbias_enable,
  input wire logic [3:0]  double_slope_level,
  input wire logic [3:0]  triple_slope_level,
  input wire logic [2:0]  antibloom_level,
  input wire logic [1:0]  cascode_level,
  input wire logic        testpattern_enable,
  input wire logic        inject_level,
  input wire logic        frontend_powerup,
  input wire logic        bandgap_powerup,
  input wire logic        external_resistor,
  input wire logic [3:0]  precharge_trim,
  input wire logic [3:0]  colbias_trim,
  input wire logic [3:0]  pump_current_trim,
  input wire logic [3:0]  frontend_current_trim,
  input wire logic [3:0]  converter_trim,
  input wire logic [6:0]  gain_stage_trim,
  input wire logic [3:0]  selector_first_stage_trim,
  input wire logic [3:0]  selector_second_stage_trim,
  input wire logic [3:0]  selector_delay_trim
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed accepted write, and the field groups of each register
  wire        wr  = psel & penable & pready & pwrite & pclk_en & !pslverr;
  wire [2:0]  ctl = {colbias_enable, mux_powerup, core_powerup};
  wire [14:0] lvl = {inject_level, testpattern_enable, cascode_level, antibloom_level,
                     triple_slope_level, double_slope_level};
  wire [12:0] cfg = {pump_current_trim, colbias_trim, precharge_trim, external_resistor};
  wire [14:0] fet = {gain_stage_trim, converter_trim, frontend_current_trim};
  wire [11:0] sel = {selector_delay_trim, selector_second_stage_trim, selector_first_stage_trim};
  wire [59:0] all = {ctl, lvl, frontend_powerup, bandgap_powerup, cfg, fet, sel};
  property p_ctl; wr && paddr == 12'h0a0 |=> ctl == $past(pwdata[2:0]); endproperty
  a_ctl: assert property (p_ctl) else $error("control bits wrong");
  property p_lvl; wr && paddr == 12'h0a4 |=> lvl == $past(pwdata[14:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("level fields wrong");
  property p_fe; wr && paddr == 12'h0c0 |=> frontend_powerup == $past(pwdata[0]); endproperty
  a_fe: assert property (p_fe) else $error("front-end power wrong");
  property p_cfg; wr && paddr == 12'h104 |=> cfg == $past({pwdata[15:4], pwdata[0]}); endproperty
  a_cfg: assert property (p_cfg) else $error("reference setup wrong");
  property p_fet; wr && paddr == 12'h108 |=> fet == $past(pwdata[14:0]); endproperty
  a_fet: assert property (p_fet) else $error("front-end trims wrong");
  property p_sel; wr && paddr == 12'h10c |=> sel == $past(pwdata[11:0]); endproperty
  a_sel: assert property (p_sel) else $error("selector trims wrong");
  property p_hold; !wr |=> $stable(all); endproperty
  a_hold: assert property (p_hold) else $error("field moved without write");
  property p_rdy; psel && !penable && pclk_en |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing wrong");
  property p_rdl; psel && penable && pready && !pwrite && paddr == 12'h0a4
    |-> prdata == {17'h0, lvl}; endproperty
  a_rdl: assert property (p_rdl) else $error("level readback wrong");
  // a low clock enable must freeze the answer path and every stored field
  property p_frz; !pclk_en |=> $stable({pready, pslverr, prdata, all}); endproperty
  a_frz: assert property (p_frz) else $error("state moved while clock enable low");
  c_wr: cover property (wr && paddr == 12'h0a4);
  c_err: cover property (pready && pslverr);
  c_b2b: cover property (wr ##1 psel && !penable);
endmodule
bind abc_bank abc_bank_chk u_chk (.*);
`default_nettype wire

//--- tb/tb_abc_bank.sv
// self-checking bench for the bias configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_abc_bank;
  import abc_pkg::*;
  logic        pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, v, s = 32'd59;
  logic        pready, pslverr, core_powerup, mux_powerup, colbias_enable, testpattern_enable;
  logic        inject_level, frontend_powerup, bandgap_powerup, external_resistor;
  logic [3:0]  double_slope_level, triple_slope_level, precharge_trim, colbias_trim;
  logic [3:0]  pump_current_trim, frontend_current_trim, converter_trim, selector_delay_trim;
  logic [3:0]  selector_first_stage_trim, selector_second_stage_trim;
  logic [2:0]  antibloom_level;
  logic [1:0]  cascode_level;
  logic [6:0]  gain_stage_trim;
  logic [11:0] adr [7] = '{12'h0a0, 12'h0a4, 12'h0c0, 12'h100, 12'h104, 12'h108, 12'h10c};
  logic [11:0] bad [3] = '{12'h0a8, 12'h0a2, 12'hffc};
  logic [15:0] rst [7] = '{RST_COLUMN_READOUT_ENABLES, RST_PIXEL_ARRAY_LEVELS,
    RST_FRONTEND_POWERUP, RST_REFERENCE_POWERUP, RST_CURRENT_REFERENCE_SETUP,
    RST_FRONTEND_CURRENT_TRIMS, RST_COLUMN_SELECTOR_TRIMS};
  logic [15:0] m [7];
  logic [17:0] q [$];
  logic [17:0] e;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  abc_bank dut (.*);
  always #4 pclk = ~pclk;
  function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task final_report();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; psel stays up so a following call runs back to back
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er,
            input logic [15:0] ex);
    q.push_back({~w, er, ex});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    penable <= 1'b0;
  endtask
  task idle();
    psel <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_all();
    for (int i = 0; i < 7; i++) xfer(1'b0, adr[i], xs(), 1'b0, m[i]);
    idle();
  endtask
  task fields_chk();
    chk(32'({colbias_enable, mux_powerup, core_powerup}), 32'(m[0][2:0]));
    chk(32'({inject_level, testpattern_enable, cascode_level, antibloom_level,
      triple_slope_level, double_slope_level}), 32'(m[1][14:0]));
    chk(32'(frontend_powerup), 32'(m[2][0]));
    chk(32'(bandgap_powerup), 32'(m[3][0]));
    chk(32'(external_resistor), 32'(m[4][0]));
    chk(32'({pump_current_trim, colbias_trim, precharge_trim}), 32'(m[4][15:4]));
    chk(32'({gain_stage_trim, converter_trim, frontend_current_trim}), 32'(m[5][14:0]));
    chk(32'({selector_delay_trim, selector_second_stage_trim, selector_first_stage_trim}),
      32'(m[6][11:0]));
  endtask
  // bus watcher: compare every completed transfer with the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (presetn && psel && penable && pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk(32'(pslverr), 32'(e[16]));
      if (e[17]) chk(prdata, {16'h0, e[15:0]});
    end
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    m = rst;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    fields_chk();
    rd_all();
    pclk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    pclk_en <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 7; i++) begin
        v = (r == 0) ? '1 : (r == 1) ? '0 : xs();
        xfer(1'b1, adr[i], v, 1'b0, 16'h0);
        m[i] = (i == 1) ? (v[15:0] & 16'h7fff) : v[15:0];
      end
      idle();
      fields_chk();
      rd_all();
    end
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, bad[k], xs(), 1'b1, 16'h0);
      xfer(1'b0, bad[k], xs(), 1'b1, 16'h0);
    end
    idle();
    rd_all();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m = rst;
    @(posedge pclk);
    fields_chk();
    rd_all();
    chk(q.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
